// ### hw/asp_pkg.sv
/*
  asp_pkg: constants for the sample packetizer control block.
  assumes: single 20 MHz clock domain, 32-bit peripheral register access.
*/
`default_nettype none
package asp_pkg;
  localparam logic [7:0] ASP_OFF_PIN0 = 8'h00;
  localparam logic [7:0] ASP_OFF_PIN1 = 8'h04;
  localparam logic [7:0] ASP_OFF_PIN2 = 8'h08;
  localparam logic [7:0] ASP_OFF_PIN3 = 8'h0c;
  localparam logic [7:0] ASP_OFF_GEN = 8'h20;
  localparam int ASP_NPINS = 4;
  localparam int ASP_BIT_EN = 0;
  localparam int ASP_BIT_CAL = 1;
  localparam int ASP_BIT_DROP = 24;
  localparam int ASP_CNT_LSB = 8;
  localparam int ASP_WID_LSB = 16;
  localparam int ASP_DEST_LSB = 8;
  localparam logic [1:0] ASP_WID_RST = 2'h1;
  localparam logic [7:0] ASP_CNT_RST = 8'h01;
  localparam logic [7:0] ASP_CNT_OPEN = 8'h00;
  localparam logic [2:0] ASP_CAL_PULSES = 3'h6;
  typedef enum logic [1:0] {
    ASP_W8 = 2'b00,
    ASP_W16 = 2'b01,
    ASP_WRSV = 2'b10,
    ASP_W32 = 2'b11
  } asp_width_type;
  typedef enum logic [1:0] {
    ASP_IDLE = 2'b00,
    ASP_HDR = 2'b01,
    ASP_DATA = 2'b10,
    ASP_END = 2'b11
  } asp_state_type;
endpackage
`default_nettype wire

// ### hw/asp_ctrl.sv
/*
  asp_ctrl: adc general control, pin control registers and sample packetizer.
  assumes: converter returns a 12-bit result one cycle after its start strobe;
  network accepts a byte or control token when NET_READY is high.
*/
// Behaviour
// - sticky dropped flag bit 24, cleared by a general control read unless a new drop lands in the same cycle.
// - width field bits 17:16 reset 1; 8/16/32-bit, code 2 reserved, left-justified.
// - 8-bit mode sends upper eight result bits as one byte.
// - 16-bit mode pads four zeros, high byte sent first.
// - 32-bit mode pads twenty zeros, bytes sent most significant first.
// - count field bits 15:8 reset 1 sets samples per packet.
// - count zero keeps packet open until a control register access while idle, or a sample from another pin.
// - calibration bit 1 selects internal 0.8V reference instead of pin.
// - general control bit 0 enables the converter, reset 0.
// - pin control registers ignore writes while converter enabled.
// - six sampling pulses after enable calibrate and send nothing.
// - seventh and later pulses convert and deliver samples.
// - each sampling rising edge converts next enabled pin in rotation.
// - pin register bits 31:8 hold destination channel-end upper 24 bits.
// - pin register bit 0 reset 0 includes pin in conversions.
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl
  import asp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  input wire logic SAMPLE_CLK,
  output logic CONV_START,
  output logic [1:0] CONV_PIN,
  output logic CONV_CAL,
  input wire logic CONV_DONE,
  input wire logic [11:0] CONV_RESULT,
  output logic NET_VALID,
  output logic NET_CTRL,
  output logic [7:0] NET_DATA,
  input wire logic NET_READY
);
  // software-visible general control fields
  logic en_r;
  logic cal_r;
  logic [1:0] wid_r;
  logic [7:0] cnt_r;
  logic drop_r;

  // per-pin routing and enables, frozen while converting
  logic [23:0] dest_r [ASP_NPINS];
  logic [ASP_NPINS-1:0] pin_en_r;

  // sampling edge, warm-up count and rotation
  logic samp_d_r;
  logic [2:0] cal_cnt_r;
  logic [1:0] next_pin_r;
  logic [1:0] cur_pin_r;

  // packet sender; one holding word only, so a result that finds it busy is lost
  logic [1:0] open_pin_r;
  logic pkt_open_r;
  logic [7:0] in_pkt_r;
  logic [31:0] samp_r;
  logic samp_full_r;
  logic [1:0] byte_r;
  logic [1:0] hdr_r;
  asp_state_type st_r;

  // decode and handshake helpers
  logic samp_rise;
  logic found;
  logic [1:0] pick;
  logic any_access;
  logic ctl_access;
  logic pin_wr_ok;
  logic take;
  logic [31:0] packed_val;

  // packs a 12-bit result left-justified for the selected width
  function automatic logic [31:0] pack_sample(input logic [11:0] res, input logic [1:0] w);
    case (w)
      ASP_W8: pack_sample = {24'h000000, res[11:4]};
      ASP_W16: pack_sample = {16'h0000, res, 4'h0};
      default: pack_sample = {res, 20'h00000};
    endcase
  endfunction

  // bytes per sample minus one; reserved code treated as 32-bit
  function automatic logic [1:0] last_byte(input logic [1:0] w);
    case (w)
      ASP_W8: last_byte = 2'h0;
      ASP_W16: last_byte = 2'h1;
      default: last_byte = 2'h3;
    endcase
  endfunction

  // word-aligned pin control offsets 0x00 to 0x0c
  function automatic logic is_pin_reg(input logic [7:0] a);
    is_pin_reg = (a[7:4] == 4'h0) && (a[1:0] == 2'h0);
  endfunction

  // edge detect and access decode; a mapped register access seen while the sender is idle closes an open packet
  assign samp_rise = SAMPLE_CLK & ~samp_d_r;
  assign any_access = REG_WR | REG_RD;
  assign ctl_access = any_access && (REG_ADDR == ASP_OFF_GEN || is_pin_reg(REG_ADDR));
  assign pin_wr_ok = REG_WR && !en_r && is_pin_reg(REG_ADDR);
  assign take = NET_VALID && NET_READY;
  assign packed_val = pack_sample(CONV_RESULT, wid_r);

  // round-robin search for the next enabled pin from next_pin_r
  always_comb begin
    found = 1'b0;
    pick = next_pin_r;
    for (int i = 0; i < ASP_NPINS; i++) begin
      if (!found && pin_en_r[2'(next_pin_r + 2'(i))]) begin
        found = 1'b1;
        pick = 2'(next_pin_r + 2'(i));
      end
    end
  end

  // general control writes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      en_r <= 1'b0;
      cal_r <= 1'b0;
      wid_r <= ASP_WID_RST;
      cnt_r <= ASP_CNT_RST;
    end else if (REG_WR && REG_ADDR == ASP_OFF_GEN) begin
      en_r <= REG_WDATA[ASP_BIT_EN];
      cal_r <= REG_WDATA[ASP_BIT_CAL];
      wid_r <= REG_WDATA[ASP_WID_LSB +: 2];
      cnt_r <= REG_WDATA[ASP_CNT_LSB +: 8];
    end
  end

  // per-pin control, frozen while enabled
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pin_en_r <= '0;
      for (int i = 0; i < ASP_NPINS; i++) begin
        dest_r[i] <= 24'h000000;
      end
    end else if (pin_wr_ok) begin
      dest_r[REG_ADDR[3:2]] <= REG_WDATA[ASP_DEST_LSB +: 24];
      pin_en_r[REG_ADDR[3:2]] <= REG_WDATA[0];
    end
  end

  // read data; reserved bits read zero, unmapped reads give zero
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      if (REG_ADDR == ASP_OFF_GEN) begin
        REG_RDATA <= {7'h00, drop_r, 6'h00, wid_r, cnt_r, 6'h00, cal_r, en_r};
      end else if (is_pin_reg(REG_ADDR)) begin
        REG_RDATA <= {dest_r[REG_ADDR[3:2]], 7'h00, pin_en_r[REG_ADDR[3:2]]};
      end else begin
        REG_RDATA <= 32'h00000000;
      end
    end
  end

  // dropped flag: a new drop in the read cycle wins over the clear
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      drop_r <= 1'b0;
    end else if (CONV_DONE && samp_full_r) begin
      drop_r <= 1'b1;
    end else if (REG_RD && REG_ADDR == ASP_OFF_GEN) begin
      drop_r <= 1'b0;
    end
  end

  // sampling edge detect and calibration pulse counting
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      samp_d_r <= 1'b0;
      cal_cnt_r <= 3'h0;
      CONV_START <= 1'b0;
      CONV_PIN <= 2'h0;
      CONV_CAL <= 1'b0;
      next_pin_r <= 2'h0;
      cur_pin_r <= 2'h0;
    end else begin
      samp_d_r <= SAMPLE_CLK;
      CONV_START <= 1'b0;
      CONV_CAL <= cal_r;
      if (!en_r) begin
        cal_cnt_r <= 3'h0; // re-enabling restarts calibration
      end else if (samp_rise) begin
        if (cal_cnt_r != ASP_CAL_PULSES) begin
          cal_cnt_r <= 3'(cal_cnt_r + 3'h1);
        end else if (found) begin
          CONV_START <= 1'b1;
          CONV_PIN <= pick;
          cur_pin_r <= pick;
          next_pin_r <= 2'(pick + 2'h1);
        end
      end
    end
  end

  // packet sender: header, sample bytes, end token
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_r <= ASP_IDLE;
      NET_VALID <= 1'b0;
      NET_CTRL <= 1'b0;
      NET_DATA <= 8'h00;
      samp_r <= 32'h00000000;
      samp_full_r <= 1'b0;
      byte_r <= 2'h0;
      hdr_r <= 2'h0;
      pkt_open_r <= 1'b0;
      open_pin_r <= 2'h0;
      in_pkt_r <= 8'h00;
    end else begin
      // a completed conversion lands in the holding word unless it is still busy
      if (CONV_DONE && !samp_full_r) begin
        samp_r <= packed_val;
        samp_full_r <= 1'b1;
      end
      case (st_r)
        // between samples: close, open a new packet, or continue the open one
        ASP_IDLE: begin
          if (pkt_open_r && (ctl_access || (samp_full_r && cur_pin_r != open_pin_r))) begin
            st_r <= ASP_END;
            NET_VALID <= 1'b1;
            NET_CTRL <= 1'b1;
            NET_DATA <= 8'h01;
          end else if (samp_full_r && !pkt_open_r) begin
            st_r <= ASP_HDR;
            open_pin_r <= cur_pin_r;
            hdr_r <= 2'h0;
            NET_VALID <= 1'b1;
            NET_CTRL <= 1'b0;
            NET_DATA <= dest_r[cur_pin_r][23:16];
          end else if (samp_full_r) begin
            st_r <= ASP_DATA;
            byte_r <= 2'h0;
            NET_VALID <= 1'b1;
            NET_CTRL <= 1'b0;
            NET_DATA <= samp_r[8*last_byte(wid_r) +: 8];
          end
        end
        // three destination bytes, high first
        ASP_HDR: begin
          if (take) begin
            if (hdr_r == 2'h2) begin
              pkt_open_r <= 1'b1;
              in_pkt_r <= 8'h00;
              byte_r <= 2'h0;
              st_r <= ASP_DATA;
              NET_DATA <= samp_r[8*last_byte(wid_r) +: 8];
            end else begin
              hdr_r <= 2'(hdr_r + 2'h1);
              NET_DATA <= (hdr_r == 2'h0) ? dest_r[open_pin_r][15:8] : dest_r[open_pin_r][7:0];
            end
          end
        end
        // sample bytes, most significant first
        ASP_DATA: begin
          if (take) begin
            if (byte_r == last_byte(wid_r)) begin
              samp_full_r <= 1'b0; // frees holding word for next conversion
              in_pkt_r <= 8'(in_pkt_r + 8'h01);
              if (cnt_r != ASP_CNT_OPEN && 8'(in_pkt_r + 8'h01) >= cnt_r) begin
                st_r <= ASP_END;
                NET_CTRL <= 1'b1;
                NET_DATA <= 8'h01;
              end else begin
                st_r <= ASP_IDLE;
                NET_VALID <= 1'b0;
              end
            end else begin
              byte_r <= 2'(byte_r + 2'h1);
              NET_DATA <= samp_r[8*(2'(last_byte(wid_r) - byte_r - 2'h1)) +: 8];
            end
          end
        end
        // end token releases the route
        ASP_END: begin
          if (take) begin
            st_r <= ASP_IDLE;
            pkt_open_r <= 1'b0;
            NET_VALID <= 1'b0;
            NET_CTRL <= 1'b0;
          end
        end
        default: st_r <= ASP_IDLE;
      endcase
    end
  end
endmodule // asp_ctrl
`default_nettype wire

// ### testbench/asp_ctrl_props.sv
/* asp_ctrl_props: port checker for asp_ctrl.
   assumes: bound onto asp_ctrl, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl_props
  import asp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic SAMPLE_CLK,
  input wire logic CONV_START,
  input wire logic CONV_CAL,
  input wire logic CONV_DONE,
  input wire logic NET_VALID,
  input wire logic NET_CTRL,
  input wire logic [7:0] NET_DATA,
  input wire logic NET_READY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic en_r, cal_r, sq_r;
  logic [2:0] edg_r;
  wire gen_rd = REG_RD && REG_ADDR == ASP_OFF_GEN && !CONV_DONE;
  // warm-up edges, saturating so long runs never wrap
  always_ff @(posedge REF_CLK) begin
    sq_r <= SAMPLE_CLK;
    if (RST || !en_r) edg_r <= 3'h0;
    else if (SAMPLE_CLK && !sq_r && edg_r != 3'h7) edg_r <= edg_r + 3'h1;
  end
  // software copy of enable and input select
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      en_r <= 1'b0;
      cal_r <= 1'b0;
    end else if (REG_WR && REG_ADDR == ASP_OFF_GEN) begin
      en_r <= REG_WDATA[ASP_BIT_EN];
      cal_r <= REG_WDATA[ASP_BIT_CAL];
    end
  end
  AST_START_PULSE: assert property (CONV_START |=> !CONV_START)
    else $error("start too long");
  AST_START_EDGE: assert property (CONV_START |-> $past(SAMPLE_CLK) && !$past(SAMPLE_CLK, 2))
    else $error("start without edge");
  AST_WARMUP: assert property (CONV_START |-> edg_r == 3'h7)
    else $error("start in warm-up");
  AST_DISABLED: assert property (!$past(en_r) |-> !CONV_START)
    else $error("start while off");
  AST_CAL_SEL: assert property (CONV_START |-> CONV_CAL == $past(cal_r))
    else $error("wrong input select");
  AST_NET_HOLD: assert property (NET_VALID && !NET_READY |=>
    NET_VALID && $stable(NET_DATA) && $stable(NET_CTRL)) else $error("token changed");
  AST_DROP_CLR: assert property (gen_rd ##1 !CONV_DONE [*2] ##1 gen_rd |=> !REG_RDATA[ASP_BIT_DROP])
    else $error("drop flag kept");
  AST_UNMAPPED: assert property (REG_RD && REG_ADDR[7:4] == 4'h4 |=> REG_RDATA == 32'h0)
    else $error("unmapped not zero");
  cover property (CONV_START);
  cover property (NET_VALID && NET_READY && NET_CTRL);
  cover property (REG_RD ##1 REG_RDATA[ASP_BIT_DROP]);
endmodule // asp_ctrl_props
`default_nettype wire

// ### testbench/asp_far.sv
/* asp_far: converter and network sink facing asp_ctrl.
   assumes: shares the clock of asp_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module asp_far (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic slow,
  input wire logic stall,
  input wire logic [11:0] res_in,
  output logic done,
  output logic [11:0] result,
  output logic ready
);
  logic ph_r;
  // answer a cycle after start; junk between answers so stale data shows
  always_ff @(posedge clk) begin
    done <= start && !rst;
    result <= rst ? 12'ha5a : start ? res_in : ~result;
  end
  // sink: prompt, every other cycle when slow, never when stalled
  always_ff @(posedge clk) ph_r <= rst ? 1'b0 : !ph_r;
  assign ready = !stall && (!slow || ph_r);
endmodule // asp_far
`default_nettype wire

// ### testbench/tb_top.sv
/* tb_top: self-checking bench for asp_ctrl.
   assumes: asp_far as partner, checker bound below. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asp_pkg::*;
  logic REF_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, SAMPLE_CLK = 1'b0, slow = 1'b0, stall = 1'b0;
  logic CONV_START, CONV_CAL, CONV_DONE, NET_VALID, NET_CTRL, NET_READY, scal;
  logic [1:0] CONV_PIN, spin, w;
  logic [7:0] REG_ADDR = 8'h0, NET_DATA;
  logic [11:0] res = 12'h0, CONV_RESULT;
  logic [15:0] cal_x;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, rdv, v;
  logic [8:0] toks[$];
  int seed = 32'hea33, mismatches = 0, comparisons = 0, starts = 0, n;
  asp_ctrl i_asp_ctrl (.REF_CLK(REF_CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SAMPLE_CLK(SAMPLE_CLK), .CONV_START(CONV_START),
    .CONV_PIN(CONV_PIN), .CONV_CAL(CONV_CAL), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
    .NET_VALID(NET_VALID), .NET_CTRL(NET_CTRL), .NET_DATA(NET_DATA), .NET_READY(NET_READY));
  asp_far i_asp_far (.clk(REF_CLK), .rst(RST), .start(CONV_START), .slow(slow), .stall(stall),
    .res_in(res), .done(CONV_DONE), .result(CONV_RESULT), .ready(NET_READY));
  always #25 REF_CLK = ~REF_CLK;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one-cycle strobe; read data is taken the cycle after
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(negedge REF_CLK);
    REG_WR = wr;
    REG_RD = !wr;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge REF_CLK);
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    @(negedge REF_CLK);
    rdv = REG_RDATA;
  endtask
  // sampling port pulses, wide enough to cover a short packet
  task automatic pulse(input int k);
    repeat (k) begin
      @(negedge REF_CLK);
      SAMPLE_CLK = 1'b1;
      repeat (5) @(negedge REF_CLK);
      SAMPLE_CLK = 1'b0;
      repeat (5) @(negedge REF_CLK);
    end
  endtask
  // s samples: header bytes, left-justified sample bytes high first, then end token
  task automatic pkt(input logic [23:0] d, input int s);
    n = w == 2'h0 ? 1 : w == 2'h1 ? 2 : 4;
    v = {res, 20'h0};
    for (int k = 0; k < 80 && toks.size() < s * n + 4; k++) @(negedge REF_CLK);
    repeat (4) @(negedge REF_CLK);
    chk("tokens", toks.size(), s * n + 4);
    for (int j = 0; j < s * n + 4; j++) begin
      chk("token", toks[j], j < 3 ? {1'b0, d[23 - 8 * j -: 8]} :
        j < s * n + 3 ? {1'b0, v[31 - 8 * ((j - 3) % n) -: 8]} : 9'h101);
    end
    // first sample word of a 16-bit packet, kept for the scale check
    if (toks.size() > 4) cal_x = {toks[3][7:0], toks[4][7:0]};
    toks.delete();
  endtask
  // accepted tokens and conversion requests
  always @(posedge REF_CLK) begin
    if (NET_VALID && NET_READY) toks.push_back({NET_CTRL, NET_DATA});
    if (CONV_START) begin
      starts++;
      spin = CONV_PIN;
      scal = CONV_CAL;
    end
  end
  initial begin
    repeat (10) @(negedge REF_CLK);
    RST = 1'b0;
    acc(1'b0, ASP_OFF_GEN, 32'h0);
    chk("gen", rdv, 32'h00010100);
    acc(1'b1, ASP_OFF_PIN0, 32'h12345601);
    acc(1'b0, ASP_OFF_PIN0, 32'h0);
    chk("pin0", rdv, 32'h12345601);
    acc(1'b0, 8'h40, 32'h0);
    chk("unmapped", rdv, 32'h0);
    acc(1'b1, ASP_OFF_GEN, 32'h00010101);
    pulse(6);
    chk("warmup", toks.size() + starts, 0);
    acc(1'b1, ASP_OFF_PIN0, 32'h0);
    acc(1'b0, ASP_OFF_PIN0, 32'h0);
    chk("locked", rdv, 32'h12345601);
    for (int i = 0; i < 9; i++) begin
      w = i % 3 == 2 ? 2'h3 : 2'(i % 3);
      slow = 1'($random(seed));
      res = i == 0 ? 12'hfff : i == 1 ? 12'h001 : 12'($random(seed));
      acc(1'b1, ASP_OFF_GEN, {14'h0, w, 16'h0101});
      pulse(1);
      pkt(24'h123456, 1);
    end
    // count zero: the packet stays open until a register access closes it
    w = 2'h1;
    slow = 1'b0;
    acc(1'b1, ASP_OFF_GEN, 32'h00010001);
    pulse(2);
    acc(1'b0, ASP_OFF_PIN0, 32'h0);
    pkt(24'h123456, 2);
    // calibration input: the first sample after the switch is not used
    acc(1'b1, ASP_OFF_GEN, 32'h00010103);
    pulse(1);
    chk("cal", scal, 1'b1);
    pkt(24'h123456, 1);
    res = 12'h3e8;
    pulse(1);
    pkt(24'h123456, 1);
    chk("uv", 32'(cal_x) * (800000 / 32'(cal_x)), 32'd800000);
    // a stalled network makes the second result find the holding word busy
    stall = 1'b1;
    pulse(2);
    acc(1'b0, ASP_OFF_GEN, 32'h0);
    chk("drop", rdv[24], 1'b1);
    acc(1'b0, ASP_OFF_GEN, 32'h0);
    chk("drop_clr", rdv[24], 1'b0);
    stall = 1'b0;
    pkt(24'h123456, 1);
    acc(1'b1, ASP_OFF_GEN, 32'h0);
    n = starts;
    pulse(7);
    chk("off", starts, n);
    acc(1'b1, ASP_OFF_PIN1, 32'habcdef01);
    acc(1'b1, ASP_OFF_GEN, 32'h00000101);
    pulse(7);
    for (int i = 0; i < 3; i++) begin
      w = spin;
      pulse(1);
      chk("rotation", spin, w ^ 2'h1);
    end
    tally_and_finish();
  end
  // watchdog, far beyond the roughly 600 cycles the run needs
  initial begin
    repeat (20000) @(posedge REF_CLK);
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_top
bind asp_ctrl asp_ctrl_props i_asp_ctrl_props (.REF_CLK(REF_CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SAMPLE_CLK(SAMPLE_CLK),
  .CONV_START(CONV_START), .CONV_CAL(CONV_CAL), .CONV_DONE(CONV_DONE), .NET_VALID(NET_VALID),
  .NET_CTRL(NET_CTRL), .NET_DATA(NET_DATA), .NET_READY(NET_READY));
`default_nettype wire
